// ### serial_rx_flow_control.sv
// Serial receive queue with in-band stop/resume flow control and peek support.
// Assumes rxd is already synchronous to clk and the register master never overlaps strobes.
`timescale 1ns/1ps
module serial_rx_flow_control
(
	input  wire logic                                clk,
	input  wire logic                                arst_n,
	input  wire serial_rx_flow_control_pkg::bus_req_t bus_req,
	output logic [31:0]                              rdata,
	input  wire logic                                rxd,
	output logic                                     txd
);

	typedef enum logic [3:0]
	{
		RX_IDLE  = 4'h1,
		RX_START = 4'h2,
		RX_DATA  = 4'h4,
		RX_STOP  = 4'h8
	} rx_state_t;

	typedef enum logic [1:0]
	{
		TX_IDLE  = 2'h1,
		TX_SHIFT = 2'h2
	} tx_state_t;

	rx_state_t   rx_state_reg;
	logic [13:0] rx_div_reg;
	logic [2:0]  rx_bits_reg;
	logic [7:0]  rx_shift_reg;
	logic        rx_valid_reg;
	logic [7:0]  rx_byte_reg;
	tx_state_t   tx_state_reg;
	logic [13:0] tx_div_reg;
	logic [3:0]  tx_bits_reg;
	logic [8:0]  tx_shift_reg;
	logic        txd_reg;
	logic [7:0]  mem_reg [serial_rx_flow_control_pkg::QUEUE_DEPTH];
	logic [7:0]  wr_ptr_reg;
	logic [7:0]  rd_ptr_reg;
	logic [8:0]  count_reg;
	logic [8:0]  low_reg;
	logic [8:0]  high_reg;
	logic [2:0]  rate_code_reg;
	logic [7:0]  peek_idx_reg;
	logic [7:0]  xoff_cnt_reg;
	logic [7:0]  ovr_cnt_reg;
	logic        xon_pend_reg;
	logic        xoff_out_reg;
	logic        txc_pend_reg;
	logic [7:0]  txc_data_reg;
	logic [31:0] rdata_reg;
	logic [13:0] bit_div;
	logic        push_ev;
	logic        drop_ev;
	logic        pop_ev;
	logic        xoff_req;
	logic        peek_short;
	logic        xon_req;
	logic        start_xoff;
	logic        start_ovr;
	logic        start_xon;
	logic        start_txc;
	logic [7:0]  wr_char;
	logic        rate_ok;
	serial_rx_flow_control_pkg::status_t status;

	assign rdata = rdata_reg;
	assign txd   = txd_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Configuration registers
	// Rate code accepts binary 1..6 or ASCII '1'..'6'; anything else leaves the rate alone
	assign wr_char = bus_req.wdata[7:0];
	assign rate_ok = (wr_char >= 8'h01 && wr_char <= 8'h06)
		|| (wr_char >= 8'h31 && wr_char <= 8'h36);
	assign bit_div = serial_rx_flow_control_pkg::bit_cycles(rate_code_reg);

	// Nonvolatile storage of the rate lives outside; firmware rewrites the code after power-up
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rate_code_reg <= serial_rx_flow_control_pkg::RATE_CODE_RST;
		else if (bus_req.wr && bus_req.addr == serial_rx_flow_control_pkg::ADDR_RATE && rate_ok)
			rate_code_reg <= wr_char[2:0];
	end

	// Water marks, rewritten by the command interpreter
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			low_reg  <= serial_rx_flow_control_pkg::LOW_RST;
			high_reg <= serial_rx_flow_control_pkg::HIGH_RST;
		end
		else if (bus_req.wr)
		begin
			if (bus_req.addr == serial_rx_flow_control_pkg::ADDR_LOW)
				low_reg <= bus_req.wdata[8:0];
			if (bus_req.addr == serial_rx_flow_control_pkg::ADDR_HIGH)
				high_reg <= bus_req.wdata[8:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Receiver: half-bit start check, then sample mid-bit
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_state_reg <= RX_IDLE;
			rx_div_reg   <= 14'h0000;
			rx_bits_reg  <= 3'h0;
			rx_shift_reg <= 8'h00;
			rx_valid_reg <= 1'b0;
			rx_byte_reg  <= 8'h00;
		end
		else
		begin
			rx_valid_reg <= 1'b0;
			if (rx_state_reg != RX_IDLE && rx_div_reg != 14'h0000)
				rx_div_reg <= rx_div_reg - 14'h0001;
			unique case (rx_state_reg)
				RX_IDLE:
					if (!rxd)
					begin
						rx_state_reg <= RX_START;
						rx_div_reg   <= {1'b0, bit_div[13:1]};
					end
				RX_START:
					if (rx_div_reg == 14'h0000)
					begin
						rx_state_reg <= rxd ? RX_IDLE : RX_DATA; // Glitch rejection
						rx_div_reg   <= bit_div - 14'h0001;
						rx_bits_reg  <= 3'h0;
					end
				RX_DATA:
					if (rx_div_reg == 14'h0000)
					begin
						rx_shift_reg <= {rxd, rx_shift_reg[7:1]};
						rx_bits_reg  <= rx_bits_reg + 3'h1;
						rx_div_reg   <= bit_div - 14'h0001;
						if (rx_bits_reg == 3'h7)
							rx_state_reg <= RX_STOP;
					end
				RX_STOP:
					if (rx_div_reg == 14'h0000)
					begin
						rx_state_reg <= RX_IDLE;
						rx_valid_reg <= rxd; // Framing errors are dropped silently
						rx_byte_reg  <= rx_shift_reg;
					end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Receive queue
	assign push_ev = rx_valid_reg && count_reg != serial_rx_flow_control_pkg::QUEUE_FULL;
	assign drop_ev = rx_valid_reg && count_reg == serial_rx_flow_control_pkg::QUEUE_FULL;
	assign pop_ev  = bus_req.rd && bus_req.addr == serial_rx_flow_control_pkg::ADDR_DATA
		&& count_reg != 9'h000;

	always_ff @(posedge clk)
	begin
		if (push_ev)
			mem_reg[wr_ptr_reg] <= rx_byte_reg;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_ptr_reg <= 8'h00;
			rd_ptr_reg <= 8'h00;
			count_reg  <= 9'h000;
		end
		else
		begin
			if (push_ev)
				wr_ptr_reg <= wr_ptr_reg + 8'h01;
			if (pop_ev)
				rd_ptr_reg <= rd_ptr_reg + 8'h01;
			count_reg <= count_reg + {8'h00, push_ev} - {8'h00, pop_ev};
		end
	end

	// Look-ahead index for the peek window
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			peek_idx_reg <= 8'h00;
		else if (bus_req.wr && bus_req.addr == serial_rx_flow_control_pkg::ADDR_PEEK_IDX)
			peek_idx_reg <= wr_char;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Flow-control decisions
	assign xoff_req   = push_ev && (count_reg + 9'h001) >= high_reg;
	assign peek_short = bus_req.wr && bus_req.addr == serial_rx_flow_control_pkg::ADDR_PEEK_IDX
		&& count_reg <= {1'b0, wr_char};
	// Level test keeps one resume per episode: the flag falls as the resume leaves
	assign xon_req = xoff_out_reg && !xon_pend_reg
		&& (count_reg <= low_reg || peek_short);

	// Transmit priority: stop, overrun marker, resume, then software characters
	assign start_xoff = tx_state_reg == TX_IDLE && xoff_cnt_reg != 8'h00;
	assign start_ovr  = tx_state_reg == TX_IDLE && xoff_cnt_reg == 8'h00 && ovr_cnt_reg != 8'h00;
	assign start_xon  = tx_state_reg == TX_IDLE && xoff_cnt_reg == 8'h00 && ovr_cnt_reg == 8'h00
		&& xon_pend_reg;
	assign start_txc  = tx_state_reg == TX_IDLE && xoff_cnt_reg == 8'h00 && ovr_cnt_reg == 8'h00
		&& !xon_pend_reg && txc_pend_reg;

	// Pending counts saturate; a request and a send in one cycle cancel out
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			xoff_cnt_reg <= 8'h00;
			ovr_cnt_reg  <= 8'h00;
		end
		else
		begin
			if (xoff_req && !start_xoff && xoff_cnt_reg != 8'hff)
				xoff_cnt_reg <= xoff_cnt_reg + 8'h01;
			else if (!xoff_req && start_xoff)
				xoff_cnt_reg <= xoff_cnt_reg - 8'h01;
			if (drop_ev && !start_ovr && ovr_cnt_reg != 8'hff)
				ovr_cnt_reg <= ovr_cnt_reg + 8'h01;
			else if (!drop_ev && start_ovr)
				ovr_cnt_reg <= ovr_cnt_reg - 8'h01;
		end
	end

	// Resume request and outstanding-stop flag
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			xon_pend_reg <= 1'b0;
			xoff_out_reg <= 1'b0;
		end
		else
		begin
			if (xon_req)
				xon_pend_reg <= 1'b1;
			else if (start_xon)
				xon_pend_reg <= 1'b0;
			if (start_xoff)
				xoff_out_reg <= 1'b1;
			else if (start_xon)
				xoff_out_reg <= 1'b0;
		end
	end

	// Software character for the return line, held until the transmitter takes it
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			txc_pend_reg <= 1'b0;
			txc_data_reg <= 8'h00;
		end
		else if (bus_req.wr && bus_req.addr == serial_rx_flow_control_pkg::ADDR_TX_CHAR)
		begin
			txc_pend_reg <= 1'b1;
			txc_data_reg <= wr_char;
		end
		else if (start_txc)
			txc_pend_reg <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmitter: start bit, eight data LSB first, stop bit
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_state_reg <= TX_IDLE;
			tx_div_reg   <= 14'h0000;
			tx_bits_reg  <= 4'h0;
			tx_shift_reg <= 9'h1ff;
			txd_reg      <= 1'b1;
		end
		else
		begin
			unique case (tx_state_reg)
				TX_IDLE:
					if (start_xoff || start_ovr || start_xon || start_txc)
					begin
						tx_state_reg <= TX_SHIFT;
						txd_reg      <= 1'b0;
						tx_div_reg   <= bit_div - 14'h0001;
						tx_bits_reg  <= 4'h9;
						if (start_xoff)
							tx_shift_reg <= {1'b1, serial_rx_flow_control_pkg::XOFF_CHAR};
						else if (start_ovr)
							tx_shift_reg <= {1'b1, serial_rx_flow_control_pkg::OVR_CHAR};
						else if (start_xon)
							tx_shift_reg <= {1'b1, serial_rx_flow_control_pkg::XON_CHAR};
						else
							tx_shift_reg <= {1'b1, txc_data_reg};
					end
				TX_SHIFT:
					if (tx_div_reg != 14'h0000)
						tx_div_reg <= tx_div_reg - 14'h0001;
					else if (tx_bits_reg == 4'h0)
						tx_state_reg <= TX_IDLE;
					else
					begin
						txd_reg      <= tx_shift_reg[0];
						tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
						tx_bits_reg  <= tx_bits_reg - 4'h1;
						tx_div_reg   <= bit_div - 14'h0001;
					end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register read port; data stand one cycle only
	assign status = '{xon_pend: xon_pend_reg, xoff_out: xoff_out_reg,
		tx_busy: tx_state_reg != TX_IDLE, count: count_reg};

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rdata_reg <= 32'h0000_0000;
		else if (!bus_req.rd)
			rdata_reg <= 32'h0000_0000;
		else
			case (bus_req.addr)
				serial_rx_flow_control_pkg::ADDR_RATE:      rdata_reg <= {29'h0, rate_code_reg};
				serial_rx_flow_control_pkg::ADDR_LOW:       rdata_reg <= {23'h0, low_reg};
				serial_rx_flow_control_pkg::ADDR_HIGH:      rdata_reg <= {23'h0, high_reg};
				serial_rx_flow_control_pkg::ADDR_STATUS:    rdata_reg <= {20'h0, status};
				serial_rx_flow_control_pkg::ADDR_DATA:
					rdata_reg <= pop_ev ? {24'h0, mem_reg[rd_ptr_reg]} : 32'h0000_0000;
				serial_rx_flow_control_pkg::ADDR_PEEK_IDX:  rdata_reg <= {24'h0, peek_idx_reg};
				serial_rx_flow_control_pkg::ADDR_PEEK_DATA:
					rdata_reg <= {24'h0, mem_reg[rd_ptr_reg + peek_idx_reg]};
				default:                                    rdata_reg <= 32'h0000_0000;
			endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_xoff_on_high:
		assert property (xoff_req |=> xoff_cnt_reg != 8'h00 || tx_shift_reg[7:0] == 8'h13)
		else $error("stop request lost");
	a_overrun_marker:
		assert property (drop_ev |=> ovr_cnt_reg != 8'h00 && count_reg <= 9'h100)
		else $error("overrun not reported");
	a_xoff_sets_flag:
		assert property (start_xoff |=> xoff_out_reg && !txd_reg)
		else $error("stop send did not set flag");
	a_xon_needs_xoff:
		assert property (start_xon |-> xoff_out_reg ##1 !xoff_out_reg)
		else $error("resume without outstanding stop");
	a_single_xon:
		assert property (start_xon |=> !xon_pend_reg [*8])
		else $error("second resume in one episode");
	a_pop_drains:
		assert property (pop_ev && !push_ev |=> count_reg == $past(count_reg) - 9'h001)
		else $error("pop did not drain");
	a_peek_resume:
		assert property (peek_short && xoff_out_reg && !xon_pend_reg |=> xon_pend_reg)
		else $error("short peek gave no resume");
	a_low_resume:
		assert property (xoff_out_reg && count_reg <= low_reg |=> xon_pend_reg || !xoff_out_reg)
		else $error("low mark gave no resume");
	a_frame_stop:
		assert property (tx_state_reg == TX_IDLE |-> txd_reg)
		else $error("line not idle high");
	a_rate_legal:
		assert property (rate_code_reg >= 3'h1 && rate_code_reg <= 3'h6)
		else $error("illegal rate code");

	c_overrun:  cover property (drop_ev);
	c_xon_sent: cover property (start_xon);
	c_peek_short: cover property (peek_short && xoff_out_reg);

endmodule

// ### serial_rx_flow_control_pkg.sv
// Constants, types and the character table of the serial receive path.
// Assumes one 40 MHz clock and a plain register port driven by a local controller.
//
// Summary of operation
// - Both ends start at 115200 bit/s, eight data bits, no parity.
// - Line rate selectable among 4800, 9600, 19200, 38400, 57600 and 115200.
// - Host line carries host characters; return line carries display characters, flow control too.
// - Received characters queue in a 256-byte buffer that command processing drains.
// - Occupancy reaching or exceeding the high mark sends stop character 0x13.
// - Each further character queued above the high mark sends one more stop.
// - Draining continues after a stop, so occupancy falls while the host waits.
// - Occupancy dropping to the low mark sends resume character 0x11.
// - Resume goes out only while a stop is outstanding, once per episode.
// - After reset the low mark is 20 and the high mark 166.
// - Both marks can be rewritten at run time by a configuration command.
// - A character arriving with 256 bytes queued is dropped and 0xff is sent.
// - Queue is deeper than 128 bytes since a consumer peeks up to 128 ahead.
// - Peek beyond queued data while stopped sends a resume character.
// - Rate code 1 to 6, binary or ASCII digit, back to 6 (115200) at every reset.
package serial_rx_flow_control_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_HZ = 40_000_000;
	localparam int RATE_1 = 4800;
	localparam int RATE_2 = 9600;
	localparam int RATE_3 = 19200;
	localparam int RATE_4 = 38400;
	localparam int RATE_5 = 57600;
	localparam int RATE_6 = 115200;
	// Bit period in clock cycles, rounded to nearest
	localparam logic [13:0] DIV_1 = 14'((CLK_HZ + RATE_1 / 2) / RATE_1);
	localparam logic [13:0] DIV_2 = 14'((CLK_HZ + RATE_2 / 2) / RATE_2);
	localparam logic [13:0] DIV_3 = 14'((CLK_HZ + RATE_3 / 2) / RATE_3);
	localparam logic [13:0] DIV_4 = 14'((CLK_HZ + RATE_4 / 2) / RATE_4);
	localparam logic [13:0] DIV_5 = 14'((CLK_HZ + RATE_5 / 2) / RATE_5);
	localparam logic [13:0] DIV_6 = 14'((CLK_HZ + RATE_6 / 2) / RATE_6);
	localparam logic [2:0]  RATE_CODE_RST = 3'h6;

	////////////////////////////////////////////////////////////////////////////////
	// Queue and characters
	localparam int          QUEUE_DEPTH = 256;
	localparam logic [8:0]  QUEUE_FULL  = 9'h100;
	localparam logic [8:0]  LOW_RST     = 9'h014;
	localparam logic [8:0]  HIGH_RST    = 9'h0a6;
	localparam logic [7:0]  XOFF_CHAR   = 8'h13;
	localparam logic [7:0]  XON_CHAR    = 8'h11;
	localparam logic [7:0]  OVR_CHAR    = 8'hff;
	localparam logic [7:0]  ASCII_ZERO  = 8'h30;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0] ADDR_RATE      = 8'h00;
	localparam logic [7:0] ADDR_LOW       = 8'h04;
	localparam logic [7:0] ADDR_HIGH      = 8'h08;
	localparam logic [7:0] ADDR_STATUS    = 8'h0c;
	localparam logic [7:0] ADDR_DATA      = 8'h10;
	localparam logic [7:0] ADDR_PEEK_IDX  = 8'h14;
	localparam logic [7:0] ADDR_PEEK_DATA = 8'h18;
	localparam logic [7:0] ADDR_TX_CHAR   = 8'h1c;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_t;

	typedef struct packed {
		logic       xon_pend;
		logic       xoff_out;
		logic       tx_busy;
		logic [8:0] count;
	} status_t;

	// Bit period for a rate code; illegal codes never reach here
	function automatic logic [13:0] bit_cycles(input logic [2:0] code);
		case (code)
			3'h1:    return DIV_1;
			3'h2:    return DIV_2;
			3'h3:    return DIV_3;
			3'h4:    return DIV_4;
			3'h5:    return DIV_5;
			default: return DIV_6;
		endcase
	endfunction

endpackage

// ### host_link_model.sv
// Host model on the far side of the two-wire serial link.
// Assumes one clock; bit period in clock cycles comes from the bench.
`timescale 1ns/1ps
module host_link_model
(
	input  wire logic clk,
	output logic      rxd,
	input  wire logic txd
);
	int          n_rx;
	int          n_bad;
	int          n_overrun;
	logic [7:0]  last_char;
	logic        stopped;
	logic [13:0] bit_cyc;     // Bit period in clocks, set by the bench per rate
	logic        ignore_stop; // Lets the bench push past a stop on purpose

	initial
	begin
		rxd = 1'b1;
		bit_cyc = serial_rx_flow_control_pkg::DIV_6;
		ignore_stop = 1'b0;
		n_rx = 0;
		n_bad = 0;
		n_overrun = 0;
		last_char = 8'h00;
		stopped = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sender: waits out a pause before each character, bounded so a lost resume
	// shows up as a link fault rather than a hang
	task automatic send_byte(input logic [7:0] b);
		int guard;
		guard = 0;
		while (stopped && !ignore_stop && guard < 40000)
		begin
			@(posedge clk);
			guard++;
		end
		// A resume that never came counts as a link fault
		if (guard == 40000)
			n_bad++;
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk);
			rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
			repeat (bit_cyc - 1) @(posedge clk);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Receiver: samples on the falling clock edge, clear of the launch edge
	always
	begin
		logic [7:0] c;
		@(negedge txd);
		repeat (bit_cyc / 2) @(negedge clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (bit_cyc) @(negedge clk);
			c[i] = txd;
		end
		repeat (bit_cyc) @(negedge clk);
		if (txd !== 1'b1 || c === 8'hxx)
			n_bad++;
		last_char = c;
		n_rx++;
		if (c === 8'h13)
			stopped = 1'b1;
		if (c === 8'h11)
			stopped = 1'b0;
		if (c === 8'hff)
			n_overrun++;
	end
endmodule

// ### serial_rx_flow_control_bench.sv
// Self-checking bench for the serial receive queue and its flow control.
// Assumes the host model file is compiled first.
`timescale 1ns/1ps
module serial_rx_flow_control_bench;
	typedef struct packed {logic [7:0] addr; logic [31:0] exp;} row_t;

	logic                                 clk;
	logic                                 arst_n;
	serial_rx_flow_control_pkg::bus_req_t bus_req;
	logic [31:0]                          rdata;
	logic                                 rxd;
	logic                                 txd;
	int                                   failures;
	int                                   n_tests;
	logic [31:0]                          v;
	row_t                                 rst_rows [7];
	row_t                                 rate_rows [12];

	serial_rx_flow_control i_dut (.clk(clk), .arst_n(arst_n), .bus_req(bus_req),
		.rdata(rdata), .rxd(rxd), .txd(txd));
	host_link_model i_host (.clk(clk), .rxd(rxd), .txd(txd));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checking and bus tasks
	task automatic complete_run();
		$display("failures=%0d n_tests=%0d", failures, n_tests);
		if (failures == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_req.wr <= 1'b1;
		bus_req.addr <= a;
		bus_req.wdata <= d;
		@(posedge clk);
		bus_req.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample there
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		bus_req.rd <= 1'b1;
		bus_req.addr <= a;
		@(posedge clk);
		bus_req.rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask

	task automatic wait_rx(input int n);
		int k;
		for (k = 0; k < 20000 && i_host.n_rx < n; k++)
			@(posedge clk);
		if (k == 20000)
		begin
			failures++;
			complete_run();
		end
	endtask

	// One character to the device; a link fault or a lost resume ends the run at once
	task automatic send(input logic [7:0] b);
		i_host.send_byte(b);
		if (i_host.n_bad != 0)
		begin
			failures++;
			complete_run();
		end
	endtask

	task automatic do_reset();
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (12) @(posedge clk);
		check("txd in reset", {31'h0, txd}, 32'h1);
		arst_n <= 1'b1;
		i_host.bit_cyc <= serial_rx_flow_control_pkg::DIV_6;
		foreach (rst_rows[i])
		begin
			rd(rst_rows[i].addr, v);
			check("reset value", v, rst_rows[i].exp);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		arst_n = 1'b0;
		bus_req = '0;
		failures = 0;
		n_tests = 0;
		rst_rows = '{'{8'h00, 32'h6}, '{8'h04, 32'h14}, '{8'h08, 32'ha6}, '{8'h0c, 32'h0},
			'{8'h10, 32'h0}, '{8'h14, 32'h0}, '{8'h20, 32'h0}};
		rate_rows = '{'{8'h01, 32'h1}, '{8'h02, 32'h2}, '{8'h03, 32'h3}, '{8'h04, 32'h4},
			'{8'h05, 32'h5}, '{8'h06, 32'h6}, '{8'h07, 32'h6}, '{8'h00, 32'h6},
			'{8'h31, 32'h1}, '{8'h33, 32'h3}, '{8'h36, 32'h6}, '{8'h35, 32'h5}};
		do_reset();
		// Rate codes, binary and as digits; out-of-range codes leave the rate alone
		foreach (rate_rows[i])
		begin
			wr(8'h00, {24'h0, rate_rows[i].addr});
			rd(8'h00, v);
			check("rate code", v, rate_rows[i].exp);
		end
		i_host.bit_cyc <= serial_rx_flow_control_pkg::DIV_5;
		send(8'h6b);
		repeat (4) @(posedge clk);
		rd(8'h10, v);
		check("byte at 57600", v, 32'h6b);
		wr(8'h00, 32'h6);
		i_host.bit_cyc <= serial_rx_flow_control_pkg::DIV_6;
		// Small marks keep the run short
		wr(8'h04, 32'h1);
		wr(8'h08, 32'h3);
		rd(8'h08, v);
		check("high mark", v, 32'h3);
		send(8'h41);
		send(8'h42);
		repeat (4) @(posedge clk);
		rd(8'h0c, v);
		check("no stop below mark", i_host.n_rx, 32'h0);
		check("queue count", v, 32'h2);
		send(8'h43);
		wait_rx(1);
		check("stop char", {24'h0, i_host.last_char}, 32'h13);
		rd(8'h0c, v);
		check("stop flag", v[10], 1'b1);
		i_host.ignore_stop <= 1'b1;
		send(8'h44);
		wait_rx(2);
		check("second stop", {24'h0, i_host.last_char}, 32'h13);
		i_host.ignore_stop <= 1'b0;
		rd(8'h10, v);
		check("queue head", v, 32'h41);
		wr(8'h14, 32'h1);
		rd(8'h18, v);
		check("peek", v, 32'h43);
		rd(8'h10, v);
		// Second stop still has its stop bit on the line, so the sender shows busy
		rd(8'h0c, v);
		check("still stopped", v[10:0], 11'h602);
		rd(8'h10, v);
		check("third pop", v, 32'h43);
		wait_rx(3);
		check("resume", {24'h0, i_host.last_char}, 32'h11);
		rd(8'h0c, v);
		check("flag clear", v[10], 1'b0);
		rd(8'h10, v);
		check("last pop", v, 32'h44);
		repeat (4000) @(posedge clk);
		check("single resume", i_host.n_rx, 32'h3);
		// Look-ahead past queued data while paused
		wr(8'h08, 32'h2);
		send(8'h51);
		send(8'h52);
		wait_rx(4);
		wr(8'h14, 32'h2);
		wait_rx(5);
		check("peek resume", {24'h0, i_host.last_char}, 32'h11);
		rd(8'h10, v);
		rd(8'h10, v);
		check("pop after peek", v, 32'h52);
		wr(8'h1c, 32'h5a);
		wait_rx(6);
		check("return char", {24'h0, i_host.last_char}, 32'h5a);
		check("framing", i_host.n_bad, 32'h0);
		check("no overrun", i_host.n_overrun, 32'h0);
		do_reset();
		complete_run();
	end
endmodule
